// File: verilog/timer_host_port.v
// Purpose: bus decode, setup parsing and three counters of interval timer
// Assumes: bus and counter pins are asynchronous and resynchronised here
// Notes: counter clocks are sampled, so they must run below core_clk / 4
`timescale 1ns/100ps
`include "timer_map.vh"
module timer_host_port #(
   parameter CHANNELS = 3
) (
   // clock and reset
   input wire core_clk,
   input wire rst_n,
   // processor bus
   input wire cs_n,
   input wire rd_n,
   input wire wr_n,
   input wire port_select_lo,
   input wire port_select_hi,
   input wire [7:0] data_in,
   output wire [7:0] data_out,
   output wire data_oe_n,
   // counter pins
   input wire [CHANNELS-1:0] timer_clk,
   input wire [CHANNELS-1:0] timer_gate,
   output wire [CHANNELS-1:0] wave_out
);
   localparam SYNC_W = 13 + 2 * CHANNELS;

   wire [SYNC_W-1:0] sync_q;
   wire s_cs_n;
   wire s_rd_n;
   wire s_wr_n;
   wire [1:0] s_port;
   wire [7:0] s_data;
   wire [CHANNELS-1:0] s_tclk;
   wire [CHANNELS-1:0] s_gate;

   // bus pins pass two flops before any decode
   pin_sync #(
      .WIDTH(SYNC_W),
      .RESET_VAL({3'b111, {(SYNC_W-3){1'b0}}})
   ) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in({cs_n, rd_n, wr_n, port_select_hi, port_select_lo,
                 data_in, timer_clk, timer_gate}),
      .sync_out(sync_q)
   );

   assign s_cs_n = sync_q[SYNC_W-1];
   assign s_rd_n = sync_q[SYNC_W-2];
   assign s_wr_n = sync_q[SYNC_W-3];
   assign s_port = sync_q[SYNC_W-4:SYNC_W-5];
   assign s_data = sync_q[SYNC_W-6:SYNC_W-13];
   assign s_tclk = sync_q[2*CHANNELS-1:CHANNELS];
   assign s_gate = sync_q[CHANNELS-1:0];

   // modes 2 and 3 ignore the top code bit
   function [2:0] norm_mode;
      input [2:0] code;
      begin
         if (code[1])
            norm_mode = {1'b0, code[1:0]};
         else
            norm_mode = code;
      end
   endfunction

   // write capture: data and port held while the strobe is low
   reg wr_armed_ff;
   reg [7:0] wdata_ff;
   reg [1:0] wport_ff;
   reg rd_live_ff;
   reg [1:0] rport_ff;
   reg [7:0] dout_ff;
   reg doe_n_ff;
   wire wr_stb;
   wire rd_act;
   wire rd_done;
   wire [2:0] set_mode;
   wire [8*CHANNELS-1:0] rd_bytes;
   wire [CHANNELS-1:0] rd_ok;

   assign wr_stb = wr_armed_ff & s_wr_n & ~s_cs_n;
   assign rd_act = ~s_cs_n & ~s_rd_n & s_wr_n;
   assign rd_done = rd_live_ff & ~rd_act;
   assign set_mode = norm_mode({wdata_ff[`MODE_B2_BIT],
                                wdata_ff[`MODE_B1_BIT],
                                wdata_ff[`MODE_B0_BIT]});

   always @(posedge core_clk) begin
      if (!rst_n) begin
         wr_armed_ff <= 1'b0;
         wdata_ff <= 8'h00;
         wport_ff <= 2'h0;
         rd_live_ff <= 1'b0;
         rport_ff <= 2'h0;
         dout_ff <= 8'h00;
         doe_n_ff <= 1'b1;
      end else begin
         if (s_cs_n) begin
            wr_armed_ff <= 1'b0;
         end else if (~s_wr_n & s_rd_n) begin
            wr_armed_ff <= 1'b1;
            wdata_ff <= s_data;
            wport_ff <= s_port;
         end else if (s_wr_n) begin
            wr_armed_ff <= 1'b0;
         end
         rd_live_ff <= rd_act;
         if (rd_act)
            rport_ff <= s_port;
         // drive only during a selected read of a readable counter
         if (rd_act && s_port != `PORT_SETUP && rd_ok[s_port]) begin
            doe_n_ff <= 1'b0;
            dout_ff <= rd_bytes[8*s_port +: 8];
         end else begin
            doe_n_ff <= 1'b1;
         end
      end
   end

   assign data_out = dout_ff;
   assign data_oe_n = doe_n_ff;

   genvar i;
   generate
      for (i = 0; i < CHANNELS; i = i + 1) begin : g_cnt
         reg [2:0] mode_ff;
         reg [1:0] acc_ff;
         reg bcd_ff;
         reg prog_ff;
         reg [15:0] cr_ff;
         reg [15:0] ce_ff;
         reg wflip_ff;
         reg rflip_ff;
         reg pend_ff;
         reg run_ff;
         reg null_ff;
         reg out_ff;
         reg trig_ff;
         reg tclk_prev_ff;
         reg gate_prev_ff;
         wire [15:0] dec;
         wire setup_hit;
         wire cnt_hit;
         wire tick;
         wire gate;
         wire gate_rise;
         wire can_trig;

         assign gate = s_gate[i];
         assign gate_rise = gate & ~gate_prev_ff;
         // load and count on the falling edge of the counter's own clock
         assign tick = tclk_prev_ff & ~s_tclk[i];
         assign setup_hit = wr_stb && wport_ff == `PORT_SETUP &&
            {wdata_ff[`PICK_HI_BIT], wdata_ff[`PICK_LO_BIT]} == i &&
            {wdata_ff[`ACCESS_HI_BIT], wdata_ff[`ACCESS_LO_BIT]} !=
            `ACC_LATCH;
         // count bytes before any setup word are dropped
         assign cnt_hit = wr_stb && wport_ff == i && prog_ff;
         assign can_trig = pend_ff | ~null_ff;

         count_step u_step (
            .value(ce_ff),
            .bcd(bcd_ff),
            .by_two(mode_ff == `MODE_3),
            .result(dec)
         );

         always @(posedge core_clk) begin
            if (!rst_n) begin
               mode_ff <= `MODE_RESET;
               acc_ff <= `ACC_RESET;
               bcd_ff <= 1'b0;
               prog_ff <= 1'b0;
               cr_ff <= `COUNT_CLEAR;
               ce_ff <= `COUNT_CLEAR;
               wflip_ff <= 1'b0;
               rflip_ff <= 1'b0;
               pend_ff <= 1'b0;
               run_ff <= 1'b0;
               null_ff <= 1'b1;
               out_ff <= `OUT_RESET;
               trig_ff <= 1'b0;
               tclk_prev_ff <= 1'b0;
               gate_prev_ff <= 1'b0;
            end else begin
               tclk_prev_ff <= s_tclk[i];
               gate_prev_ff <= gate;
               if (setup_hit) begin
                  mode_ff <= set_mode;
                  acc_ff <= {wdata_ff[`ACCESS_HI_BIT],
                             wdata_ff[`ACCESS_LO_BIT]};
                  bcd_ff <= wdata_ff[`BASE_BIT];
                  prog_ff <= 1'b1;
                  ce_ff <= `COUNT_CLEAR;
                  null_ff <= 1'b1;
                  wflip_ff <= 1'b0;
                  rflip_ff <= 1'b0;
                  pend_ff <= 1'b0;
                  run_ff <= 1'b0;
                  trig_ff <= 1'b0;
                  out_ff <= (set_mode == `MODE_0) ? 1'b0 : 1'b1;
               end else begin
                  // a trigger arriving with its consumption is kept
                  if (gate_rise)
                     trig_ff <= 1'b1;
                  else if (tick)
                     trig_ff <= 1'b0;
                  if (tick) begin
                     case (mode_ff)
                        `MODE_0, `MODE_4: begin
                           if (pend_ff) begin
                              ce_ff <= cr_ff;
                              pend_ff <= 1'b0;
                              run_ff <= 1'b1;
                              null_ff <= 1'b0;
                              out_ff <= (mode_ff == `MODE_4) | 1'b0 ?
                                 1'b1 : 1'b0;
                           end else if (run_ff & gate) begin
                              ce_ff <= dec;
                              if (mode_ff == `MODE_0) begin
                                 if (ce_ff == `COUNT_ONE)
                                    out_ff <= 1'b1;
                              end else begin
                                 out_ff <= ce_ff != `COUNT_ONE;
                                 if (ce_ff == `COUNT_ONE)
                                    run_ff <= 1'b0;
                              end
                           end else if (mode_ff == `MODE_4) begin
                              out_ff <= 1'b1;
                           end
                        end
                        `MODE_1, `MODE_5: begin
                           if ((trig_ff | gate_rise) & can_trig) begin
                              ce_ff <= cr_ff;
                              pend_ff <= 1'b0;
                              run_ff <= 1'b1;
                              null_ff <= 1'b0;
                              out_ff <= (mode_ff == `MODE_5);
                           end else if (run_ff) begin
                              ce_ff <= dec;
                              if (mode_ff == `MODE_1) begin
                                 if (ce_ff == `COUNT_ONE)
                                    out_ff <= 1'b1;
                              end else begin
                                 out_ff <= ce_ff != `COUNT_ONE;
                                 if (ce_ff == `COUNT_ONE)
                                    run_ff <= 1'b0;
                              end
                           end else begin
                              out_ff <= 1'b1;
                           end
                        end
                        `MODE_2, `MODE_3: begin
                           // a count of one in mode 2 is the host's fault
                           if (((pend_ff & ~run_ff) | trig_ff | gate_rise)
                               & can_trig & gate) begin
                              ce_ff <= (mode_ff == `MODE_3) ?
                                 {cr_ff[15:1], 1'b0} : cr_ff;
                              pend_ff <= 1'b0;
                              run_ff <= 1'b1;
                              null_ff <= 1'b0;
                              out_ff <= 1'b1;
                           end else if (run_ff & gate) begin
                              if (mode_ff == `MODE_2) begin
                                 if (ce_ff == `COUNT_ONE) begin
                                    ce_ff <= cr_ff;
                                    pend_ff <= 1'b0;
                                    out_ff <= 1'b1;
                                 end else begin
                                    ce_ff <= dec;
                                    out_ff <= ce_ff != `COUNT_TWO;
                                 end
                              end else if (ce_ff == `COUNT_TWO) begin
                                 ce_ff <= {cr_ff[15:1], 1'b0};
                                 pend_ff <= 1'b0;
                                 out_ff <= ~out_ff;
                              end else begin
                                 ce_ff <= dec;
                              end
                           end
                        end
                        default: begin
                           run_ff <= 1'b0;
                        end
                     endcase
                  end
                  // gate low in the periodic modes forces the output high
                  if ((mode_ff == `MODE_2 || mode_ff == `MODE_3) && !gate)
                     out_ff <= 1'b1;
                  // writes come last so a byte landing on a tick is kept
                  if (cnt_hit) begin
                     case (acc_ff)
                        `ACC_LOW: begin
                           cr_ff <= {8'h00, wdata_ff};
                           pend_ff <= 1'b1;
                        end
                        `ACC_HIGH: begin
                           cr_ff <= {wdata_ff, 8'h00};
                           pend_ff <= 1'b1;
                        end
                        `ACC_BOTH: begin
                           if (!wflip_ff) begin
                              cr_ff[7:0] <= wdata_ff;
                              wflip_ff <= 1'b1;
                              if (mode_ff == `MODE_0) begin
                                 run_ff <= 1'b0;
                                 out_ff <= 1'b0;
                              end
                           end else begin
                              cr_ff[15:8] <= wdata_ff;
                              wflip_ff <= 1'b0;
                              pend_ff <= 1'b1;
                           end
                        end
                        default: begin
                           pend_ff <= pend_ff;
                        end
                     endcase
                  end
                  if (rd_done && rport_ff == i && acc_ff == `ACC_BOTH)
                     rflip_ff <= ~rflip_ff;
               end
            end
         end

         assign rd_ok[i] = prog_ff & ~null_ff;
         assign rd_bytes[8*i +: 8] =
            (acc_ff == `ACC_HIGH || (acc_ff == `ACC_BOTH && rflip_ff)) ?
            ce_ff[15:8] : ce_ff[7:0];
         assign wave_out[i] = out_ff;
      end
   endgenerate
endmodule

// File: verilog/timer_map.vh
// Purpose: constants shared by the interval timer host port
// Assumes: included by bare name from the timer_host_port and count_step design files
// Notes: bit positions refer to the 8-bit setup word
//
// What this block does
// - eight-bit three-state data port carries setup words and count bytes.
// - select high ignores strobes, floats data, keeps every register intact.
// - data port floats unless selected with a strobe asserted.
// - writes go to counter 0, 1, 2 or setup word by port select.
// - reads of port 0, 1, 2 return that counter's count.
// - setup word fields: counter pick, byte access, waveform mode, count base.
// - pick 00, 01, 10 choose counters; 11 marks a read-back command, which this block ignores.
// - access 00 latch (ignored here, reads stay live), 01 low only, 10 high only, 11 low then high.
// - mode codes 0 to 5; top bit ignored for modes 2 and 3.
// - base flag 0 counts 16-bit binary, 1 counts four BCD decades.
// - setup write clears counter to zero; that value is not readable.
// - written count moves into the counting element on next counter clock in modes 0 and 4; modes 1 and 5 wait for a gate trigger.
// - each counter keeps its own byte sequencing state.
// - each counter runs from its own clock input.
// - each counter's gate starts, pauses and restarts per its mode.
// - each counter drives its own waveform output per mode and count.
// - initial count zero acts as 10000H binary or 10000 BCD counts in every mode.
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

`define PORT_CNT0 2'h0
`define PORT_CNT1 2'h1
`define PORT_CNT2 2'h2
`define PORT_SETUP 2'h3

`define PICK_HI_BIT 7
`define PICK_LO_BIT 6
`define ACCESS_HI_BIT 5
`define ACCESS_LO_BIT 4
`define MODE_B2_BIT 3
`define MODE_B1_BIT 2
`define MODE_B0_BIT 1
`define BASE_BIT 0

`define PICK_READBACK 2'h3
`define ACC_LATCH 2'h0
`define ACC_LOW 2'h1
`define ACC_HIGH 2'h2
`define ACC_BOTH 2'h3

`define MODE_0 3'h0
`define MODE_1 3'h1
`define MODE_2 3'h2
`define MODE_3 3'h3
`define MODE_4 3'h4
`define MODE_5 3'h5

`define COUNT_CLEAR 16'h0000
`define COUNT_ONE 16'h0001
`define COUNT_TWO 16'h0002
`define OUT_RESET 1'b1
`define MODE_RESET 3'h0
`define ACC_RESET 2'h0

`endif

// File: verilog/pin_sync.v
// Purpose: two flip-flop synchroniser for pins from outside core_clk
// Assumes: each bit is an independent level
// Notes: multi-bit buses must be held stable for several clocks
`timescale 1ns/100ps
module pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire core_clk,
   input wire rst_n,
   // levels
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] stable_ff;

   always @(posedge core_clk) begin
      if (!rst_n) begin
         meta_ff <= RESET_VAL;
         stable_ff <= RESET_VAL;
      end else begin
         meta_ff <= async_in;
         stable_ff <= meta_ff;
      end
   end

   assign sync_out = stable_ff;
endmodule

// File: verilog/count_step.v
// Purpose: one down-count step of a counting element
// Assumes: bcd values hold valid decimal digits
// Notes: zero wraps to the top value, so zero counts as the full range
`timescale 1ns/100ps
`include "timer_map.vh"
module count_step (
   // operand
   input wire [15:0] value,
   input wire bcd,
   input wire by_two,
   // result
   output reg [15:0] result
);
   integer k;
   reg [4:0] borrow;
   reg [4:0] digit;

   always @* begin
      result = value;
      borrow = by_two ? 5'h02 : 5'h01;
      digit = 5'h00;
      if (!bcd) begin
         result = value - (by_two ? `COUNT_TWO : `COUNT_ONE);
      end else begin
         for (k = 0; k < 4; k = k + 1) begin
            digit = {1'b0, value[4*k +: 4]};
            if (digit >= borrow) begin
               digit = digit - borrow;
               borrow = 5'h00;
            end else begin
               digit = digit + 5'h0a - borrow;
               borrow = 5'h01;
            end
            result[4*k +: 4] = digit[3:0];
         end
      end
   end
endmodule

// File: testbench/timer_host_port_props.sv
// Purpose: bus and waveform checks for the interval timer host port
// Assumes: pins change just after core_clk rises
// Notes: pins pass 2 sync flops, so windows allow up to 8 cycles
`timescale 1ns/100ps
module timer_host_port_props #(
   parameter CHANNELS = 3
) (
   // clock and reset
   input wire core_clk,
   input wire rst_n,
   // processor bus
   input wire cs_n,
   input wire rd_n,
   input wire wr_n,
   input wire port_select_lo,
   input wire port_select_hi,
   input wire [7:0] data_in,
   input wire [7:0] data_out,
   input wire data_oe_n,
   // counter pins
   input wire [CHANNELS-1:0] timer_clk,
   input wire [CHANNELS-1:0] timer_gate,
   input wire [CHANNELS-1:0] wave_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire setup_c0 = !cs_n && port_select_hi && port_select_lo &&
      data_in[7:6] == 2'h0 && data_in[5:4] != 2'h0;
   AST_FLOAT_DESELECT: assert property (cs_n [*5] |-> data_oe_n)
      else $error("data port driven while deselected");
   AST_FLOAT_IDLE: assert property (rd_n [*5] |-> data_oe_n)
      else $error("data port driven without read strobe");
   AST_FLOAT_WRITE: assert property ((!wr_n) [*4] |-> data_oe_n)
      else $error("data port driven during write");
   AST_FLOAT_SETUP: assert property (
      (port_select_hi && port_select_lo) [*5] |-> data_oe_n)
      else $error("setup port read drove the bus");
   AST_DRIVE_CAUSE: assert property ($fell(data_oe_n) |->
      !$past(rd_n, 2) && !$past(cs_n, 2) && $past(wr_n, 2))
      else $error("data port driven without a read cycle");
   AST_RELEASE: assert property ($rose(rd_n) |-> ##[1:4] data_oe_n)
      else $error("data port not floated after read");
   AST_MODE0_LOW: assert property ($rose(wr_n) && setup_c0 &&
      data_in[3:1] == 3'h0 |-> ##[1:8] !wave_out[0])
      else $error("mode 0 setup left output high");
   AST_MODE_HIGH: assert property ($rose(wr_n) && setup_c0 &&
      data_in[3:1] != 3'h0 |-> ##[1:8] wave_out[0])
      else $error("other mode setup left output low");
   cover property ($fell(data_oe_n));
   cover property ($rose(wr_n) && setup_c0);
   cover property ($rose(wave_out[1]));
   cover property ($fell(wave_out[2]));
endmodule
bind timer_host_port timer_host_port_props #(.CHANNELS(CHANNELS)) chk (
   .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
   .wr_n(wr_n), .port_select_lo(port_select_lo),
   .port_select_hi(port_select_hi), .data_in(data_in),
   .data_out(data_out), .data_oe_n(data_oe_n), .timer_clk(timer_clk),
   .timer_gate(timer_gate), .wave_out(wave_out));

// File: testbench/host_bus_model.sv
// Purpose: processor side of the timer bus, issuing read and write cycles
// Assumes: write strobe stays low 4 core_clk, read strobe until driven (at most 8), at least 7 high between cycles
// Notes: address and data go to their inverse once released
`timescale 1ns/100ps
module host_bus_model (
   // clock
   input wire core_clk,
   // bus to device
   output reg cs_n,
   output reg rd_n,
   output reg wr_n,
   output reg port_select_lo,
   output reg port_select_hi,
   output reg [7:0] data_in,
   // bus from device
   input wire [7:0] data_out,
   input wire data_oe_n
);
   initial begin
      {cs_n, rd_n, wr_n} = 3'h7;
      {port_select_hi, port_select_lo} = 2'h0;
      data_in = 8'h00;
   end
   task cycle_start(input [1:0] port, input sel);
      begin
         @(posedge core_clk);
         #1;
         cs_n = ~sel;
         {port_select_hi, port_select_lo} = port;
      end
   endtask
   // select is held 2 edges past the strobe so the commit still sees it
   task cycle_end;
      begin
         repeat (2) @(posedge core_clk);
         #1;
         cs_n = 1'b1;
         {port_select_hi, port_select_lo} = ~{port_select_hi, port_select_lo};
         data_in = ~data_in;
         repeat (4) @(posedge core_clk);
         #1;
      end
   endtask
   task bus_write(input [1:0] port, input [7:0] value, input sel);
      begin
         cycle_start(port, sel);
         data_in = value;
         wr_n = 1'b0;
         repeat (4) @(posedge core_clk);
         #1;
         wr_n = 1'b1;
         cycle_end;
      end
   endtask
   task bus_read(input [1:0] port, input sel, output [7:0] value,
      output floated);
      integer i;
      begin
         cycle_start(port, sel);
         rd_n = 1'b0;
         floated = 1'b1;
         value = 8'h00;
         // look just after the edge so the registered outputs have settled
         for (i = 0; i < 8 && floated; i = i + 1) begin
            @(posedge core_clk);
            #1;
            if (data_oe_n === 1'b0) begin
               floated = 1'b0;
               value = data_out;
            end
         end
         rd_n = 1'b1;
         for (i = 0; i < 6 && data_oe_n !== 1'b1; i = i + 1) begin
            @(posedge core_clk);
            #1;
         end
         cycle_end;
      end
   endtask
endmodule

// File: testbench/timer_host_port_tb_top.sv
// Purpose: self-checking bench for the interval timer host port
// Assumes: timer clocks run 6 core_clk per phase, gates mostly low
// Notes: counts are read with gate low, so mode 0 holds them still
`timescale 1ns/100ps
module timer_host_port_tb_top;
   reg core_clk;
   reg rst_n;
   reg [2:0] timer_clk;
   reg [2:0] timer_gate;
   wire cs_n, rd_n, wr_n, ps_lo, ps_hi, data_oe_n;
   wire [7:0] data_in;
   wire [7:0] data_out;
   wire [2:0] wave_out;
   integer failures, check_count, cycles, c, k, m;
   reg [7:0] rd_val;
   reg rd_flt;
   reg [15:0] val [0:2];
   reg [1:0] acc [0:2];
   timer_host_port uut (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .port_select_lo(ps_lo),
      .port_select_hi(ps_hi), .data_in(data_in), .data_out(data_out),
      .data_oe_n(data_oe_n), .timer_clk(timer_clk),
      .timer_gate(timer_gate), .wave_out(wave_out));
   host_bus_model host (.core_clk(core_clk), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .port_select_lo(ps_lo), .port_select_hi(ps_hi),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 40000) begin
         failures = failures + 1;
         complete_run;
      end
   end
   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task check_byte(input [7:0] exp, input [7:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task check_bit(input exp, input got);
      check_byte({7'h00, exp}, {7'h00, got});
   endtask
   function [15:0] fmt(input [1:0] a, input [15:0] v);
      fmt = {a[1] ? v[15:8] : 8'h00, a[0] ? v[7:0] : 8'h00};
   endfunction
   // decimal mode borrows per nibble; zero wraps to the full range
   function [15:0] dec(input [15:0] v, input bcd);
      integer d;
      begin
         dec = v - 16'h0001;
         if (bcd) begin
            dec = v;
            d = 0;
            while (d < 4 && dec[d*4 +: 4] == 4'h0) begin
               dec[d*4 +: 4] = 4'h9;
               d = d + 1;
            end
            if (d < 4)
               dec[d*4 +: 4] = dec[d*4 +: 4] - 4'h1;
         end
      end
   endfunction
   task setup(input [1:0] pick, input [1:0] a, input [2:0] md, input bcd);
      host.bus_write(2'h3, {pick, a, md, bcd}, 1'b1);
   endtask
   task load(input [1:0] ch, input [1:0] a, input [15:0] v);
      begin
         if (a != 2'h2)
            host.bus_write(ch, v[7:0], 1'b1);
         if (a != 2'h1)
            host.bus_write(ch, v[15:8], 1'b1);
      end
   endtask
   task expect_count(input [1:0] ch, input [1:0] a, input [15:0] v);
      integer b;
      for (b = 0; b < 2; b = b + 1)
         if (a[b]) begin
            host.bus_read(ch, 1'b1, rd_val, rd_flt);
            check_bit(1'b0, rd_flt);
            check_byte(b ? v[15:8] : v[7:0], rd_val);
         end
   endtask
   task expect_float(input [1:0] ch, input sel);
      begin
         host.bus_read(ch, sel, rd_val, rd_flt);
         check_bit(1'b1, rd_flt);
      end
   endtask
   // the tick is the falling edge, seen a few core_clk later
   task tick(input [1:0] ch);
      begin
         repeat (6) @(posedge core_clk);
         #1;
         timer_clk[ch] = 1'b0;
         repeat (6) @(posedge core_clk);
         #1;
         timer_clk[ch] = 1'b1;
      end
   endtask
   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      timer_clk = 3'h7;
      timer_gate = 3'h0;
      failures = 0;
      check_count = 0;
      cycles = 0;
      k = $urandom(88218);
      repeat (4) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      check_bit(1'b1, data_oe_n);
      check_byte(8'h07, {5'h00, wave_out});
      expect_float(2'h0, 1'b1);
      expect_float(2'h3, 1'b1);
      for (m = 0; m < 8; m = m + 1) begin
         setup(2'h0, 2'h3, m[2:0], 1'b0);
         check_bit(m != 0, wave_out[0]);
         check_byte(8'h06, {5'h00, wave_out} & 8'h06);
      end
      // random counts use mode 0 only
      for (k = 0; k < 4; k = k + 1) begin
         for (c = 0; c < 3; c = c + 1) begin
            val[c] = 16'($urandom);
            acc[c] = 2'($urandom % 3) + 2'h1;
            setup(c[1:0], 2'h3, 3'h0, 1'b0);
            expect_float(c[1:0], 1'b1);
            setup(c[1:0], acc[c], 3'h0, 1'b0);
         end
         for (c = 0; c < 3; c = c + 1)
            if (acc[c] != 2'h2)
               host.bus_write(c[1:0], val[c][7:0], 1'b1);
         for (c = 0; c < 3; c = c + 1)
            if (acc[c] != 2'h1)
               host.bus_write(c[1:0], val[c][15:8], 1'b1);
         for (c = 0; c < 3; c = c + 1)
            tick(c[1:0]);
         for (c = 0; c < 3; c = c + 1)
            expect_count(c[1:0], acc[c], fmt(acc[c], val[c]));
      end
      host.bus_write(2'h0, ~val[0][7:0], 1'b0);
      host.bus_write(2'h3, 8'h30, 1'b0);
      expect_float(2'h0, 1'b0);
      host.bus_write(2'h3, 8'hf0, 1'b1);
      host.bus_write(2'h3, 8'h00, 1'b1);
      expect_count(2'h0, acc[0], fmt(acc[0], val[0]));
      setup(2'h2, 2'h3, 3'h0, 1'b0);
      host.bus_write(2'h2, 8'h5a, 1'b1);
      setup(2'h2, 2'h3, 3'h0, 1'b0);
      load(2'h2, 2'h3, 16'h1234);
      tick(2'h2);
      expect_count(2'h2, 2'h3, 16'h1234);
      for (m = 0; m < 3; m = m + 1) begin
         setup(2'h1, 2'h3, 3'h0, m == 1);
         timer_gate[1] = 1'b1;
         load(2'h1, 2'h3, (m == 2) ? 16'h0000 : 16'h0010);
         tick(2'h1);
         tick(2'h1);
         timer_gate[1] = 1'b0;
         tick(2'h1);
         expect_count(2'h1, 2'h3,
            dec((m == 2) ? 16'h0 : 16'h10, m == 1));
      end
      // code 6 must act as the rate generator: low on the third tick only
      setup(2'h2, 2'h1, 3'h6, 1'b0);
      timer_gate[2] = 1'b1;
      load(2'h2, 2'h1, 16'h0003);
      for (k = 0; k < 4; k = k + 1) begin
         check_bit(k != 3, wave_out[2]);
         tick(2'h2);
      end
      check_bit(1'b1, wave_out[2]);
      setup(2'h1, 2'h1, 3'h0, 1'b0);
      timer_gate[1] = 1'b1;
      load(2'h1, 2'h1, 16'h0002);
      for (k = 0; k < 3; k = k + 1) begin
         check_bit(1'b0, wave_out[1]);
         tick(2'h1);
      end
      check_bit(1'b1, wave_out[1]);
      complete_run;
   end
endmodule
